//--- hw/scs_pkg.sv
// Package of constants and types for the system clock select block.
package scs_pkg;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [11:0] SCS_CTRL_INDEX = 12'hF86;
	localparam logic [11:0] SCS_TRIM_INDEX = 12'hF87;
	localparam logic [11:0] SCS_STAT_INDEX = 12'hF88;
	localparam logic [31:0] SCS_CTRL_ADDR = {18'h0, SCS_CTRL_INDEX, 2'h0};
	localparam logic [31:0] SCS_TRIM_ADDR = {18'h0, SCS_TRIM_INDEX, 2'h0};
	localparam logic [31:0] SCS_STAT_ADDR = {18'h0, SCS_STAT_INDEX, 2'h0};
	// ------------------------------------------------------------------
	// Control register fields and values
	// ------------------------------------------------------------------
	localparam logic [7:0] SCS_CTRL_RESET = 8'hA0;
	localparam logic [7:0] SCS_CTRL_WMASK = 8'hBF;
	localparam logic [7:0] SCS_UNLOCK_1 = 8'hE7;
	localparam logic [7:0] SCS_UNLOCK_2 = 8'h18;
	localparam int SCS_RC_EN_BIT = 7;
	localparam int SCS_WDT_EN_BIT = 5;
	localparam int SCS_PRI_FD_BIT = 4;
	localparam int SCS_WDT_FD_BIT = 3;
	localparam logic [2:0] SCS_SEL_RC_FAST = 3'h0;
	localparam logic [2:0] SCS_SEL_RC_SLOW = 3'h1;
	localparam logic [2:0] SCS_SEL_WDT = 3'h3;
	localparam logic [2:0] SCS_SEL_EXT = 3'h4;
	// ------------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------------
	localparam int SCS_ST_PRI_FAIL = 0;
	localparam int SCS_ST_WDT_FAIL = 1;
	localparam int SCS_ST_HALTED = 2;
	localparam int SCS_ST_WDT_DEAD = 3;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int SCS_CLK_MHZ = 250;
	localparam int SCS_PRI_FAIL_NS = 1000000;
	localparam int SCS_PRI_FAIL_CYC = SCS_PRI_FAIL_NS * SCS_CLK_MHZ / 1000;
	localparam logic [13:0] SCS_WDT_FAIL_CYC = 14'h1F44;
	// ------------------------------------------------------------------
	// Unlock tracker
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SCS_LOCKED,
		SCS_GOT_FIRST,
		SCS_UNLOCKED
	} scs_lock_t;
endpackage : scs_pkg

//--- hw/scs_clock_select.sv
// System clock source selection with lockable control and fail recovery.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module scs_clock_select import scs_pkg::*; #(
	parameter int PRI_FAIL_CYC = SCS_PRI_FAIL_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic primary_clk_tick,
	input wire logic watchdog_osc_tick,
	input wire logic [7:0] trim_option_bits,
	output logic [2:0] system_clock_source_select,
	output logic precision_rc_osc_enable,
	output logic watchdog_osc_enable,
	output logic [7:0] precision_rc_trim,
	output logic primary_fail_event,
	output logic watchdog_fail_event,
	output logic clock_halted
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic sel_valid(input logic [2:0] sel);
		sel_valid = (sel == SCS_SEL_RC_FAST) || (sel == SCS_SEL_RC_SLOW) ||
			(sel == SCS_SEL_WDT) || (sel == SCS_SEL_EXT);
	endfunction : sel_valid

	typedef struct packed {
		scs_lock_t lock;
		logic [7:0] ctrl;
		logic [2:0] src;
		logic [7:0] trim;
		logic trim_init;
		logic [31:0] pri_cnt;
		logic [13:0] wdt_cnt;
		logic pri_flag;
		logic wdt_flag;
		logic wdt_dead;
		logic halted;
		logic pri_ev;
		logic wdt_ev;
	} scs_state_t;

	scs_state_t st_q;
	scs_state_t st_d;
	logic acc;
	logic wr;
	logic hit_ctrl;
	logic hit_trim;
	logic hit_stat;
	logic pri_det_on;
	logic wdt_det_on;
	logic pri_fail;
	logic wdt_fail;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign hit_ctrl = paddr == SCS_CTRL_ADDR;
	assign hit_trim = paddr == SCS_TRIM_ADDR;
	assign hit_stat = paddr == SCS_STAT_ADDR;
	assign pready = 1'b1;
	assign pslverr = acc && !(hit_ctrl || hit_trim || hit_stat);

	always_comb begin
		prdata = 32'h0;
		if (hit_ctrl) begin
			prdata[7:0] = st_q.ctrl & SCS_CTRL_WMASK;
		end else if (hit_trim) begin
			prdata[7:0] = st_q.trim;
		end else if (hit_stat) begin
			prdata[SCS_ST_PRI_FAIL] = st_q.pri_flag;
			prdata[SCS_ST_WDT_FAIL] = st_q.wdt_flag;
			prdata[SCS_ST_HALTED] = st_q.halted;
			prdata[SCS_ST_WDT_DEAD] = st_q.wdt_dead;
			prdata[5:4] = st_q.lock;
			prdata[10:8] = st_q.src;
		end
	end

	// ------------------------------------------------------------------
	// Failure detectors
	// ------------------------------------------------------------------
	// The primary detector would be meaningless on the watchdog clock.
	assign pri_det_on = st_q.ctrl[SCS_PRI_FD_BIT] && !st_q.wdt_dead &&
		(st_q.src != SCS_SEL_WDT);
	assign wdt_det_on = st_q.ctrl[SCS_WDT_FD_BIT] && !st_q.wdt_dead &&
		st_q.ctrl[SCS_WDT_EN_BIT] && (st_q.src != SCS_SEL_WDT);
	assign pri_fail = pri_det_on && !primary_clk_tick &&
		(st_q.pri_cnt == 32'(PRI_FAIL_CYC - 1));
	assign wdt_fail = wdt_det_on && !watchdog_osc_tick &&
		(st_q.wdt_cnt == SCS_WDT_FAIL_CYC - 14'h1);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.pri_ev = pri_fail;
		st_d.wdt_ev = wdt_fail;
		if (!st_q.trim_init) begin
			st_d.trim = trim_option_bits;
			st_d.trim_init = 1'b1;
		end
		if (!pri_det_on || primary_clk_tick || pri_fail) begin
			st_d.pri_cnt = 32'h0;
		end else begin
			st_d.pri_cnt = st_q.pri_cnt + 32'h1;
		end
		if (!wdt_det_on || watchdog_osc_tick || wdt_fail) begin
			st_d.wdt_cnt = 14'h0;
		end else begin
			st_d.wdt_cnt = st_q.wdt_cnt + 14'h1;
		end
		if (wdt_fail) begin
			st_d.wdt_dead = 1'b1;
		end
		if (wr && hit_ctrl) begin
			case (st_q.lock)
				SCS_LOCKED: begin
					if (pwdata[7:0] == SCS_UNLOCK_1) begin
						st_d.lock = SCS_GOT_FIRST;
					end
				end
				SCS_GOT_FIRST: begin
					if (pwdata[7:0] == SCS_UNLOCK_2) begin
						st_d.lock = SCS_UNLOCKED;
					end else if (pwdata[7:0] != SCS_UNLOCK_1) begin
						st_d.lock = SCS_LOCKED;
					end
				end
				SCS_UNLOCKED: begin
					st_d.ctrl = pwdata[7:0] & SCS_CTRL_WMASK;
					st_d.lock = SCS_LOCKED;
					if (sel_valid(pwdata[2:0])) begin
						st_d.src = pwdata[2:0];
					end else begin
						st_d.ctrl[2:0] = st_q.ctrl[2:0];
					end
				end
				default: begin
					st_d.lock = SCS_LOCKED;
				end
			endcase
		end
		if (wr && hit_trim) begin
			st_d.trim = pwdata[7:0];
		end
		if (wr && hit_stat) begin
			st_d.pri_flag = st_q.pri_flag && !pwdata[SCS_ST_PRI_FAIL];
			st_d.wdt_flag = st_q.wdt_flag && !pwdata[SCS_ST_WDT_FAIL];
		end
		// A new failure wins over a clear in the same cycle.
		if (pri_fail) begin
			st_d.pri_flag = 1'b1;
		end
		if (wdt_fail) begin
			st_d.wdt_flag = 1'b1;
		end
		// Recovery needs only the watchdog oscillator itself, not its reset.
		if (pri_fail && st_q.ctrl[SCS_WDT_EN_BIT]) begin
			st_d.src = SCS_SEL_WDT;
			st_d.ctrl[2:0] = SCS_SEL_WDT;
		end
		// Only a power-on reset ends the halt.
		if (!st_q.ctrl[SCS_PRI_FD_BIT] &&
			(((st_q.src == SCS_SEL_RC_FAST || st_q.src == SCS_SEL_RC_SLOW) &&
			!st_q.ctrl[SCS_RC_EN_BIT]) ||
			(st_q.src == SCS_SEL_WDT && !st_q.ctrl[SCS_WDT_EN_BIT]))) begin
			st_d.halted = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '{lock: SCS_LOCKED, ctrl: SCS_CTRL_RESET,
				src: SCS_SEL_RC_FAST, trim: 8'h00, trim_init: 1'b0,
				pri_cnt: 32'h0, wdt_cnt: 14'h0, pri_flag: 1'b0,
				wdt_flag: 1'b0, wdt_dead: 1'b0, halted: 1'b0,
				pri_ev: 1'b0, wdt_ev: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// The oscillator enable follows its bit alone, never the source.
	assign precision_rc_osc_enable = st_q.ctrl[SCS_RC_EN_BIT];
	assign watchdog_osc_enable = st_q.ctrl[SCS_WDT_EN_BIT];
	assign system_clock_source_select = st_q.src;
	assign precision_rc_trim = st_q.trim;
	assign primary_fail_event = st_q.pri_ev;
	assign watchdog_fail_event = st_q.wdt_ev;
	assign clock_halted = st_q.halted;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_locked_keeps;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_ctrl && st_q.lock != SCS_UNLOCKED |=>
			$stable(st_q.ctrl[7:3]);
	endproperty
	a_locked_keeps: assert property (p_locked_keeps)
		else $error("Locked control register changed.");

	property p_update_relocks;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_ctrl && st_q.lock == SCS_UNLOCKED && !pri_fail |=>
			st_q.lock == SCS_LOCKED &&
			st_q.ctrl[7:3] == ($past(pwdata[7:3]) & 5'h17);
	endproperty
	a_update_relocks: assert property (p_update_relocks)
		else $error("Unlocked write did not store and relock.");

	property p_other_keeps_unlock;
		@(posedge sys_clk) disable iff (!resetn)
		st_q.lock == SCS_GOT_FIRST && !(wr && hit_ctrl) |=>
			st_q.lock == SCS_GOT_FIRST;
	endproperty
	a_other_keeps_unlock: assert property (p_other_keeps_unlock)
		else $error("Unlock progress lost on unrelated access.");

	property p_failover;
		@(posedge sys_clk) disable iff (!resetn)
		pri_fail && st_q.ctrl[SCS_WDT_EN_BIT] |=>
			primary_fail_event && system_clock_source_select == SCS_SEL_WDT;
	endproperty
	a_failover: assert property (p_failover)
		else $error("Primary failure did not switch to watchdog.");

	property p_no_switch_wdt_off;
		@(posedge sys_clk) disable iff (!resetn)
		pri_fail && !st_q.ctrl[SCS_WDT_EN_BIT] && !(wr && hit_ctrl) |=>
			$stable(st_q.src);
	endproperty
	a_no_switch_wdt_off: assert property (p_no_switch_wdt_off)
		else $error("Switched to a disabled watchdog oscillator.");

	property p_wdt_fail_no_switch;
		@(posedge sys_clk) disable iff (!resetn)
		wdt_fail && !(wr && hit_ctrl) |=>
			watchdog_fail_event && $stable(st_q.src);
	endproperty
	a_wdt_fail_no_switch: assert property (p_wdt_fail_no_switch)
		else $error("Watchdog failure changed the source.");

	property p_wdt_dead_no_pri;
		@(posedge sys_clk) disable iff (!resetn)
		st_q.wdt_dead |=> !primary_fail_event [*2];
	endproperty
	a_wdt_dead_no_pri: assert property (p_wdt_dead_no_pri)
		else $error("Primary detection after watchdog failure.");

	property p_wdt_count;
		@(posedge sys_clk) disable iff (!resetn)
		wdt_det_on && !watchdog_osc_tick &&
			st_q.wdt_cnt == 14'h1F43 |=> watchdog_fail_event;
	endproperty
	a_wdt_count: assert property (p_wdt_count)
		else $error("Watchdog failure not raised at 8004 clocks.");

	property p_reserved_zero;
		@(posedge sys_clk) disable iff (!resetn)
		acc && !pwrite && hit_ctrl |-> prdata[6] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("Reserved control bit read as one.");

	property p_bad_second_relocks;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_ctrl && st_q.lock == SCS_GOT_FIRST &&
			pwdata[7:0] != SCS_UNLOCK_1 &&
			pwdata[7:0] != SCS_UNLOCK_2 |=>
			st_q.lock == SCS_LOCKED && $stable(st_q.ctrl[7:3]);
	endproperty
	a_bad_second_relocks: assert property (p_bad_second_relocks)
		else $error("Wrong unlock value did not relock.");

	property p_rc_stays_on;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_ctrl && st_q.lock == SCS_UNLOCKED &&
			pwdata[SCS_RC_EN_BIT] |=> precision_rc_osc_enable;
	endproperty
	a_rc_stays_on: assert property (p_rc_stays_on)
		else $error("Precision oscillator turned off on its own.");

	property p_reserved_sel_keeps;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_ctrl && st_q.lock == SCS_UNLOCKED &&
			!sel_valid(pwdata[2:0]) && !pri_fail |=>
			$stable(st_q.src) && $stable(st_q.ctrl[2:0]);
	endproperty
	a_reserved_sel_keeps: assert property (p_reserved_sel_keeps)
		else $error("Reserved select code changed the source.");

	property p_reset_value;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(resetn) |-> st_q.ctrl == SCS_CTRL_RESET &&
			st_q.src == SCS_SEL_RC_FAST && !primary_fail_event &&
			!watchdog_fail_event && !clock_halted;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("Control state wrong after reset.");

	property p_halt_on_dead;
		@(posedge sys_clk) disable iff (!resetn)
		!st_q.ctrl[SCS_PRI_FD_BIT] && !st_q.ctrl[SCS_RC_EN_BIT] &&
			(st_q.src == SCS_SEL_RC_FAST ||
			st_q.src == SCS_SEL_RC_SLOW) |=> clock_halted;
	endproperty
	a_halt_on_dead: assert property (p_halt_on_dead)
		else $error("Dead clock source did not halt.");

	property p_trim_override;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_trim |=> precision_rc_trim == $past(pwdata[7:0]);
	endproperty
	a_trim_override: assert property (p_trim_override)
		else $error("Trim write did not take effect.");

	property p_wdt_enable_bit;
		@(posedge sys_clk) disable iff (!resetn)
		wr && hit_ctrl && st_q.lock == SCS_UNLOCKED |=>
			watchdog_osc_enable == $past(pwdata[SCS_WDT_EN_BIT]);
	endproperty
	a_wdt_enable_bit: assert property (p_wdt_enable_bit)
		else $error("Watchdog enable does not follow its bit.");

	property p_pri_count_bound;
		@(posedge sys_clk) disable iff (!resetn)
		pri_det_on |-> st_q.pri_cnt < 32'(PRI_FAIL_CYC);
	endproperty
	a_pri_count_bound: assert property (p_pri_count_bound)
		else $error("Primary failure counter passed its limit.");

	property p_pri_flag_set;
		@(posedge sys_clk) disable iff (!resetn)
		pri_fail |=> st_q.pri_flag;
	endproperty
	a_pri_flag_set: assert property (p_pri_flag_set)
		else $error("Primary failure flag not set.");
endmodule : scs_clock_select

//--- tb/scs_clock_select_test.sv
// Self-checking testbench for the system clock select block.
`timescale 1ns/1ns
module scs_clock_select_test import scs_pkg::*;;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam logic [7:0] TRIM_OPT = 8'h5A;
	localparam logic [31:0] CTRL = SCS_CTRL_ADDR;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pri_ev, wdt_ev, halted, rc_en, wdt_en;
	logic [2:0] src;
	logic [7:0] trim;
	logic pri_tick = 1'b0;
	logic wdt_tick = 1'b0;
	logic pri_run = 1'b1;
	logic wdt_run = 1'b1;
	logic [31:0] rv;
	logic re;
	logic [2:0] codes [4] = '{3'h4, 3'h3, 3'h2, 3'h0};
	logic [2:0] srcs [4] = '{3'h4, 3'h3, 3'h3, 3'h0};
	int cyc = 0;
	int n;
	int errors = 0;
	int checks_done = 0;

	// A short failure count keeps the primary detector runs brief.
	scs_clock_select #(.PRI_FAIL_CYC(50)) scs_clock_select_i (
		.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .primary_clk_tick(pri_tick),
		.watchdog_osc_tick(wdt_tick), .trim_option_bits(TRIM_OPT),
		.system_clock_source_select(src),
		.precision_rc_osc_enable(rc_en), .watchdog_osc_enable(wdt_en),
		.precision_rc_trim(trim), .primary_fail_event(pri_ev),
		.watchdog_fail_event(wdt_ev), .clock_halted(halted));

	// ------------------------------------------------------------------
	// Clock and oscillator ticks
	// ------------------------------------------------------------------
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		pri_tick <= pri_run && (cyc % 10 == 0);
		wdt_tick <= wdt_run && (cyc % 25 == 0);
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h",
				$time, msg, got, exp);
		end
	endtask : chk

	// Data are taken from the cycle that ends at the accepting edge.
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (pready === 1'b1) begin
				rv = prdata;
				re = pslverr;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input logic [31:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		chk(rv, exp, m);
	endtask : rdc

	task ulk(input logic [31:0] d);
		wr(CTRL, {24'h0, SCS_UNLOCK_1});
		wr(CTRL, {24'h0, SCS_UNLOCK_2});
		wr(CTRL, d);
	endtask : ulk

	// Returns lim + 1 when no event came.
	task wait_ev(input logic which, input int lim, output int k);
		for (k = 1; k <= lim; k++) begin
			@(negedge sys_clk);
			if ((which ? wdt_ev : pri_ev) === 1'b1) break;
		end
	endtask : wait_ev

	task do_reset();
		resetn <= 1'b0;
		pri_run <= 1'b1;
		wdt_run <= 1'b1;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask : do_reset

	task wrap_up();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		wrap_up();
	end

	initial begin
		do_reset();
		chk(trim, TRIM_OPT, "trim default");
		chk({rc_en, wdt_en, src}, 5'h18, "reset outputs");
		rdc(CTRL, 32'hA0, "reset ctrl");
		wr(CTRL, 32'h55);
		wr(CTRL, 32'h18);
		wr(CTRL, 32'hE7);
		wr(CTRL, 32'h55);
		rdc(CTRL, 32'hA0, "locked ctrl");
		wr(CTRL, 32'hE7);
		rdc(SCS_TRIM_ADDR, TRIM_OPT, "trim between");
		wr(CTRL, 32'h18);
		wr(CTRL, 32'hFFFF_FFE1);
		rdc(CTRL, 32'hA1, "unlocked write");
		chk({rc_en, src}, 4'h9, "slow rc");
		wr(CTRL, 32'hA4);
		rdc(CTRL, 32'hA1, "relocked");
		for (int i = 0; i < 4; i++) begin
			ulk({24'h0, 8'hA0 | codes[i]});
			rdc(CTRL, {24'h0, 8'hA0 | srcs[i]}, "select");
			chk(src, srcs[i], "source");
		end
		apb(1'b0, 32'h0000_0100, 32'h0);
		chk(re, 1, "unmapped error");
		chk(rv, 0, "unmapped data");
		wr(SCS_TRIM_ADDR, 32'h3C);
		rdc(SCS_TRIM_ADDR, 32'h3C, "trim override");
		chk(trim, 8'h3C, "trim out");
		ulk(32'h90);
		pri_run <= 1'b0;
		wait_ev(1'b0, 200, n);
		chk(n <= 70 && n >= 40, 1, "fail time");
		chk({wdt_en, src}, 4'h0, "no failover");
		pri_run <= 1'b1;
		ulk(32'hB0);
		pri_run <= 1'b0;
		wait_ev(1'b0, 200, n);
		chk(src, SCS_SEL_WDT, "failover");
		rdc(CTRL, 32'hB3, "failover ctrl");
		chk(pri_ev, 0, "pulse");
		wait_ev(1'b0, 200, n);
		chk(n, 201, "wdt selected");
		pri_run <= 1'b1;
		ulk(32'hA0);
		ulk(32'hA8);
		wdt_run <= 1'b0;
		wait_ev(1'b1, 8100, n);
		chk(n >= 7975 && n <= 8012, 1, "wdt fail time");
		chk(src, SCS_SEL_RC_FAST, "no switch");
		rdc(SCS_STAT_ADDR, 32'hB, "status flags");
		wr(SCS_STAT_ADDR, 32'h3);
		rdc(SCS_STAT_ADDR, 32'h8, "status cleared");
		ulk(32'hB8);
		pri_run <= 1'b0;
		wait_ev(1'b0, 200, n);
		chk(n, 201, "no primary detect");
		@(posedge sys_clk);
		do_reset();
		chk(halted, 0, "running");
		ulk(32'h20);
		repeat (2) @(negedge sys_clk);
		chk({halted, rc_en}, 2'h2, "halted");
		wrap_up();
	end
endmodule : scs_clock_select_test
